/* drive_status.sv */
// Status output flags, output terminals, timed run, keypad menu and speed display
`timescale 1ns/1ps
module drive_status
  import drive_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES // Cycles per ms, shorten for simulation
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dc_bus_low, // Bus below undervoltage level
  input wire logic uv_trip, // Undervoltage protection tripped
  input wire logic sw_ilimit, // Software current limiter acting
  input wire logic hw_ilimit, // Hardware current limiter acting
  input wire logic dip_stop, // Output stopped on bus undervoltage
  input wire logic [15:0] thermal_value, // Motor thermal model value
  input wire logic [15:0] output_current,
  input wire logic retry_on, // Auto retry in effect
  input wire logic [2:0] life_expired, // Bus cap, board cap, fan
  input wire logic above_start_freq,
  input wire logic dc_brake,
  input wire logic olp_engaged, // Overload prevention at set drop rate
  input wire logic alarm_mode,
  input wire logic motor_stopped,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] ref_freq,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_run,
  input wire logic key_stop,
  input wire logic forward_run_cmd,
  output logic [1:0] term_out, // Transistor and relay terminals
  output logic run_motor,
  output logic [15:0] display_value,
  output logic display_blink,
  output logic [2:0] menu_index
);
  // Control registers
  logic [31:0] ctrl_r;
  logic [15:0] current_level_setting;
  logic [15:0] detect_delay_setting;
  logic [15:0] outsel_r;
  logic [13:0] timer_preset_r;
  logic [15:0] speed_display_coeff;
  logic [15:0] feed_time_coeff;
  logic [31:0] prdata_r;
  wire timed_run_enable = ctrl_r[CTRL_TIMED_BIT];
  wire [1:0] menu_mode_select = ctrl_r[CTRL_MENU_LSB +: 2];
  wire [2:0] restart_mode_select = ctrl_r[CTRL_RESTART_LSB +: 3];
  wire [4:0] monitor_item_select = ctrl_r[CTRL_MON_LSB +: 5];

  // Scaled speed: coefficient times frequency
  function automatic logic [31:0] speed_scale(input logic [15:0] coef, input logic [15:0] freq);
    speed_scale = coef * freq;
  endfunction

  // Feed time: coefficient over frequency times feed coefficient, zero guarded
  function automatic logic [15:0] feed_scale(input logic [15:0] coef, input logic [15:0] freq,
                                             input logic [15:0] fc);
    logic [31:0] den;
    den = freq * fc;
    feed_scale = (den == 32'h0000_0000) ? 16'hFFFF : 16'(32'(coef) / den);
  endfunction

  // Status flag chosen by an assignment code
  function automatic logic pick_flag(input logic [6:0] code, input logic [10:0] f);
    case (code)
      FN_UNDERVOLT: pick_flag = f[0];
      FN_CUR_LIMIT: pick_flag = f[1];
      FN_POWER_DIP: pick_flag = f[2];
      FN_HEAT_WARN: pick_flag = f[3];
      FN_RETRY: pick_flag = f[4];
      FN_PARTS_WEAR: pick_flag = f[5];
      FN_OUT_ACTIVE: pick_flag = f[6];
      FN_OVL_PREVENT: pick_flag = f[7];
      FN_CUR_OVER: pick_flag = f[8];
      FN_CUR_UNDER: pick_flag = f[9];
      FN_FAULT: pick_flag = f[10];
      default: pick_flag = 1'b0;
    endcase
  endfunction

  // Pin synchronisers: up, down, run, stop, forward
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [4:0] prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      prev_r <= 5'h00;
    end else begin
      sync1_r <= {forward_run_cmd, key_stop, key_run, key_down, key_up};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  wire [4:0] rise = sync2_r & ~prev_r; // Press edges: second stage against its one-cycle delayed copy
  wire fwd_s = sync2_r[4];

  // Millisecond enable from the system clock
  logic [15:0] ms_cnt_r;
  wire ms_tick = (ms_cnt_r == 16'(MS_CYCLES_P - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_r <= 16'h0000;
    end else begin
      ms_cnt_r <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
    end
  end

  // APB access decode
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  logic mapped;
  always_comb begin
    case (paddr[7:0])
      CTRL_OFS, LEVEL_OFS, DELAY_OFS, OUTSEL_OFS, TIMER_OFS, COEF_OFS, STATUS_OFS, SPEED_OFS, FEED_OFS:
        mapped = (paddr[31:8] == 24'h00_0000);
      default: mapped = 1'b0;
    endcase
  end
  // Zero wait states; error only on unmapped addresses
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // Register writes, taken in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      current_level_setting <= LEVEL_RST;
      detect_delay_setting <= DELAY_RST;
      outsel_r <= OUTSEL_RST;
      timer_preset_r <= TIMER_RST;
      {speed_display_coeff, feed_time_coeff} <= COEF_RST;
    end else if (wr_en && mapped) begin // Unmapped writes are dropped, not aliased
      case (paddr[7:0])
        CTRL_OFS: ctrl_r <= {19'h0_0000, pwdata[12:0]};
        LEVEL_OFS: current_level_setting <= pwdata[15:0];
        DELAY_OFS: detect_delay_setting <= pwdata[15:0];
        OUTSEL_OFS: outsel_r <= pwdata[15:0];
        // Out-of-range counts are clamped into the legal seconds range
        TIMER_OFS: begin
          if (pwdata[31:0] < 32'(TIMER_MIN)) begin
            timer_preset_r <= TIMER_MIN;
          end else if (pwdata[31:0] > 32'(TIMER_MAX)) begin
            timer_preset_r <= TIMER_MAX;
          end else begin
            timer_preset_r <= pwdata[13:0];
          end
        end
        COEF_OFS: {speed_display_coeff, feed_time_coeff} <= pwdata;
        default: ;
      endcase
    end
  end

  // Registered status flags
  logic uv_r;
  logic dip_r;
  logic heat_r;
  logic [15:0] over_cnt_r;
  logic [15:0] under_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_r <= 1'b0;
    end else begin
      uv_r <= dc_bus_low || uv_trip;
    end
  end

  // Power dip flag: set wins over the clear at recovery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dip_r <= 1'b0;
    end else if (dip_stop && (restart_mode_select == RESTART_DIP_A || restart_mode_select == RESTART_DIP_B)) begin
      dip_r <= 1'b1;
    end else if (out_freq >= ref_freq) begin
      dip_r <= 1'b0;
    end
  end

  // Heat warning against the shared level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heat_r <= 1'b0;
    end else begin
      heat_r <= thermal_value > current_level_setting;
    end
  end

  // Over and under current dwell counters in ms, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_cnt_r <= 16'h0000;
      under_cnt_r <= 16'h0000;
    end else begin
      if (output_current <= current_level_setting) begin
        over_cnt_r <= 16'h0000;
      end else if (ms_tick && over_cnt_r != 16'hFFFF) begin
        over_cnt_r <= over_cnt_r + 16'h0001;
      end
      if (output_current >= current_level_setting) begin
        under_cnt_r <= 16'h0000;
      end else if (ms_tick && under_cnt_r != 16'hFFFF) begin
        under_cnt_r <= under_cnt_r + 16'h0001;
      end
    end
  end
  wire over_raw = over_cnt_r > detect_delay_setting;
  wire under_raw = under_cnt_r > detect_delay_setting;

  // Minimum on-time stretchers
  logic ilimit_held;
  logic olp_held;
  logic over_held;
  logic under_held;
  min_on_hold u_hold_ilim (.pclk(pclk), .presetn(presetn), .ms_tick(ms_tick),
    .trig(sw_ilimit || hw_ilimit), .held(ilimit_held));
  min_on_hold u_hold_olp (.pclk(pclk), .presetn(presetn), .ms_tick(ms_tick),
    .trig(olp_engaged), .held(olp_held));
  min_on_hold u_hold_over (.pclk(pclk), .presetn(presetn), .ms_tick(ms_tick),
    .trig(over_raw), .held(over_held));
  min_on_hold u_hold_under (.pclk(pclk), .presetn(presetn), .ms_tick(ms_tick),
    .trig(under_raw), .held(under_held));

  // Flag vector in assignment order
  wire [10:0] flags = {alarm_mode,
                       under_held, over_held, olp_held,
                       above_start_freq || dc_brake,
                       |life_expired,
                       retry_on,
                       heat_r, dip_r, ilimit_held, uv_r};

  // Terminals: selected flag, inverted under negative logic
  logic [1:0] term_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_r <= 2'b00;
    end else begin
      term_r[0] <= pick_flag(outsel_r[6:0], flags) ^ outsel_r[OUTSEL_POL0_BIT];
      term_r[1] <= pick_flag(outsel_r[OUTSEL_CODE1_LSB +: 7], flags) ^ outsel_r[OUTSEL_POL1_BIT];
    end
  end
  assign term_out = term_r;

  // Keypad menu selection
  logic [2:0] menu_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_r <= MENU_FIRST;
    end else if (menu_mode_select == MENU_SET_ONLY) begin
      menu_r <= MENU_FIRST;
    end else if (menu_mode_select == MENU_CHECK_ONLY) begin
      menu_r <= MENU_CHECK;
    end else if (rise[0]) begin
      menu_r <= (menu_r >= MENU_LAST) ? MENU_FIRST : menu_r + 3'h1;
    end else if (rise[1]) begin
      menu_r <= (menu_r <= MENU_FIRST) ? MENU_LAST : menu_r - 3'h1;
    end
  end
  assign menu_index = menu_r;

  // Timed-run sequencer
  tr_state_t state_r;
  logic [13:0] tcount_r;
  logic [9:0] sec_ms_r;
  logic by_fwd_r;
  logic free_run_r;
  wire run_req = rise[2] || rise[4];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TR_IDLE;
      tcount_r <= TIMER_MIN;
      sec_ms_r <= 10'h000;
      by_fwd_r <= 1'b0;
    end else begin
      case (state_r)
        TR_IDLE: begin
          if (timed_run_enable && run_req) begin
            state_r <= TR_RUN;
            tcount_r <= timer_preset_r;
            sec_ms_r <= 10'h000;
            by_fwd_r <= rise[4];
          end
        end
        // Count seconds down; zero ends the run with no stop key needed
        TR_RUN: begin
          if (ms_tick) begin
            if (sec_ms_r == 10'(SEC_MS - 1)) begin
              sec_ms_r <= 10'h000;
              tcount_r <= tcount_r - 14'h0001;
              if (tcount_r == TIMER_MIN) begin
                state_r <= TR_DECEL;
              end
            end else begin
              sec_ms_r <= sec_ms_r + 10'h001;
            end
          end
        end
        TR_DECEL: begin
          if (motor_stopped) begin
            state_r <= TR_DONE;
          end
        end
        // Forward start leaves on forward release; key start on next run or stop
        TR_DONE: begin
          if (by_fwd_r ? !fwd_s : (rise[2] || rise[3])) begin
            state_r <= TR_IDLE;
          end
        end
        default: state_r <= TR_IDLE;
      endcase
    end
  end

  // Untimed running: forward level or latched run key
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_run_r <= 1'b0;
    end else if (rise[3] || timed_run_enable) begin
      free_run_r <= 1'b0;
    end else if (rise[2]) begin
      free_run_r <= 1'b1;
    end
  end
  assign run_motor = (state_r == TR_RUN) || (!timed_run_enable && (free_run_r || fwd_s));

  // Blink phase toggles every half second
  logic [9:0] blink_ms_r;
  logic phase_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_ms_r <= 10'h000;
      phase_r <= 1'b0;
    end else if (ms_tick) begin
      if (blink_ms_r == 10'(BLINK_MS - 1)) begin
        blink_ms_r <= 10'h000;
        phase_r <= !phase_r;
      end else begin
        blink_ms_r <= blink_ms_r + 10'h001;
      end
    end
  end

  // Display selection: timer count, speed monitor or end indication
  logic [15:0] disp_r;
  logic blink_r;
  wire [31:0] speed_mon = speed_scale(speed_display_coeff, out_freq);
  wire [15:0] monitor = (monitor_item_select == MON_TIMER) ?
    16'((state_r == TR_IDLE) ? timer_preset_r : tcount_r) :
    speed_mon[15:0]; // Low half only; larger products wrap on the display
  wire alt_end = (state_r == TR_DONE) && by_fwd_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_r <= 16'h0000;
      blink_r <= 1'b0;
    end else begin
      disp_r <= (alt_end && phase_r) ? END_CODE : monitor;
      blink_r <= (state_r == TR_DONE) && !by_fwd_r;
    end
  end
  assign display_value = disp_r;
  assign display_blink = blink_r;

  // Read data captured in the setup phase, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr[7:0])
        CTRL_OFS: prdata_r <= ctrl_r;
        LEVEL_OFS: prdata_r <= {16'h0000, current_level_setting};
        DELAY_OFS: prdata_r <= {16'h0000, detect_delay_setting};
        OUTSEL_OFS: prdata_r <= {16'h0000, outsel_r};
        TIMER_OFS: prdata_r <= {18'h0_0000, timer_preset_r};
        COEF_OFS: prdata_r <= {speed_display_coeff, feed_time_coeff};
        STATUS_OFS: prdata_r <= {tcount_r, state_r, menu_r, term_r, flags};
        SPEED_OFS: prdata_r <= speed_scale(speed_display_coeff, ref_freq);
        FEED_OFS: prdata_r <= {feed_scale(speed_display_coeff, ref_freq, feed_time_coeff),
                               feed_scale(speed_display_coeff, out_freq, feed_time_coeff)};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  uv_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dc_bus_low || uv_trip) |=> uv_r) else $error("undervolt flag missing");
  dip_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (dip_stop && restart_mode_select == RESTART_DIP_A) |=> dip_r) else $error("power dip flag missing");
  heat_warn_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(heat_r) |-> $past(thermal_value) > $past(current_level_setting)) else $error("heat warning wrong");
  fault_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_mode && outsel_r[6:0] == FN_FAULT && !outsel_r[OUTSEL_POL0_BIT]) |=> term_out[0])
    else $error("fault not on terminal");
  term_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(outsel_r) && $stable(flags) ##1 $stable(outsel_r) |-> $stable(term_out)) else $error("terminal unstable");
  menu_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    menu_mode_select == MENU_SET_ONLY |=> menu_index == MENU_FIRST) else $error("menu not locked");
  menu_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (menu_mode_select == 2'h2 && rise[0] && menu_r == MENU_LAST) |=> menu_r == MENU_FIRST)
    else $error("menu did not wrap");
  timer_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_preset_r >= TIMER_MIN && timer_preset_r <= TIMER_MAX) else $error("timer preset out of range");
  timer_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == TR_RUN && ms_tick && sec_ms_r == 10'(SEC_MS - 1) && tcount_r == TIMER_MIN) |=> !run_motor)
    else $error("motor not stopped at zero");
endmodule

/* drive_pkg.sv */
// Shared constants for the drive status output and timed-run block
package drive_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_ON_MS = 100;
  localparam int SEC_MS = 1000;
  localparam int BLINK_MS = 500;
  // APB byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LEVEL_OFS = 8'h04;
  localparam logic [7:0] DELAY_OFS = 8'h08;
  localparam logic [7:0] OUTSEL_OFS = 8'h0C;
  localparam logic [7:0] TIMER_OFS = 8'h10;
  localparam logic [7:0] COEF_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] SPEED_OFS = 8'h1C;
  localparam logic [7:0] FEED_OFS = 8'h20;
  // Control and output select field positions
  localparam int CTRL_TIMED_BIT = 0;
  localparam int CTRL_MENU_LSB = 1;
  localparam int CTRL_RESTART_LSB = 4;
  localparam int CTRL_MON_LSB = 8;
  localparam int OUTSEL_POL0_BIT = 7;
  localparam int OUTSEL_CODE1_LSB = 8;
  localparam int OUTSEL_POL1_BIT = 15;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] LEVEL_RST = 16'h0100;
  localparam logic [15:0] DELAY_RST = 16'h0064;
  localparam logic [15:0] OUTSEL_RST = 16'h6300;
  localparam logic [31:0] COEF_RST = 32'h0001_0001;
  // Timer count limits in seconds
  localparam logic [13:0] TIMER_MIN = 14'h0001;
  localparam logic [13:0] TIMER_MAX = 14'h270F;
  localparam logic [13:0] TIMER_RST = 14'h000A;
  // Output assignment codes
  localparam logic [6:0] FN_UNDERVOLT = 7'h03;
  localparam logic [6:0] FN_CUR_LIMIT = 7'h05;
  localparam logic [6:0] FN_POWER_DIP = 7'h06;
  localparam logic [6:0] FN_HEAT_WARN = 7'h07;
  localparam logic [6:0] FN_RETRY = 7'h1A;
  localparam logic [6:0] FN_PARTS_WEAR = 7'h1E;
  localparam logic [6:0] FN_OUT_ACTIVE = 7'h23;
  localparam logic [6:0] FN_OVL_PREVENT = 7'h24;
  localparam logic [6:0] FN_CUR_OVER = 7'h25;
  localparam logic [6:0] FN_CUR_UNDER = 7'h29;
  localparam logic [6:0] FN_FAULT = 7'h63;
  // Restart modes that raise the power dip flag
  localparam logic [2:0] RESTART_DIP_A = 3'h4;
  localparam logic [2:0] RESTART_DIP_B = 3'h5;
  // Menu modes and menu range
  localparam logic [1:0] MENU_SET_ONLY = 2'h0;
  localparam logic [1:0] MENU_CHECK_ONLY = 2'h1;
  localparam logic [2:0] MENU_FIRST = 3'h1;
  localparam logic [2:0] MENU_CHECK = 3'h2;
  localparam logic [2:0] MENU_LAST = 3'h6;
  // Monitor item that shows the timer count
  localparam logic [4:0] MON_TIMER = 5'h0D;
  // Display code for the end indication, arbitrary glyph pattern
  localparam logic [15:0] END_CODE = 16'hE0D0;
  // Timed-run sequence
  typedef enum logic [1:0] {TR_IDLE, TR_RUN, TR_DECEL, TR_DONE} tr_state_t;
endpackage

/* min_on_hold.sv */
// Stretches a condition so that each assertion lasts a minimum number of ms
`timescale 1ns/1ps
module min_on_hold
  import drive_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ms_tick, // One-cycle 1 ms enable
  input wire logic trig, // Raw condition
  output logic held // Stretched flag
);
  logic [6:0] cnt_r; // Remaining hold time in ms

  // Reload while the condition stands, run down on ms ticks after it falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 7'h00;
    end else if (trig) begin
      cnt_r <= 7'(MIN_ON_MS);
    end else if (ms_tick && cnt_r != 7'h00) begin
      cnt_r <= cnt_r - 7'h01;
    end
  end

  // Held flag; the reload means a short blip still yields the full hold
  assign held = trig || (cnt_r != 7'h00);

  hold_after_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig ##1 !trig |-> held [*8]) else $error("flag released before minimum on time");
endmodule

/* keypad_model.sv */
// Operator keypad and forward run terminal model
`timescale 1ns/1ps
module keypad_model (
  input wire logic pclk,
  input wire logic go, // One-cycle press request
  input wire logic [1:0] which, // 0 up, 1 down, 2 run, 3 stop
  input wire logic fwd_req, // Forward run level wanted
  output logic key_up,
  output logic key_down,
  output logic key_run,
  output logic key_stop,
  output logic forward_run_cmd
);
  logic [3:0] cnt_r = 4'h0; // Cycles left in the press
  logic [1:0] sel_r = 2'h0; // Key held down
  // Hold each key eight cycles so the pin sync sees one clean edge
  always_ff @(posedge pclk) begin
    if (go) begin
      cnt_r <= 4'h8;
      sel_r <= which;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign key_up = (cnt_r != 4'h0) && (sel_r == 2'h0);
  assign key_down = (cnt_r != 4'h0) && (sel_r == 2'h1);
  assign key_run = (cnt_r != 4'h0) && (sel_r == 2'h2);
  assign key_stop = (cnt_r != 4'h0) && (sel_r == 2'h3);
  assign forward_run_cmd = fwd_req;
endmodule

/* drive_status_tb.sv */
// Self-checking bench for the drive status block
`timescale 1ns/1ps
module drive_status_tb;
  import drive_pkg::*;
  localparam int MSP = 4; // Short ms: 100 ms is 400 cycles
  localparam logic [6:0] CODE [10] = '{FN_UNDERVOLT, FN_CUR_LIMIT, FN_HEAT_WARN, FN_RETRY, FN_PARTS_WEAR,
    FN_OUT_ACTIVE, FN_OVL_PREVENT, FN_CUR_OVER, FN_CUR_UNDER, FN_FAULT};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, look = 1'b0, go = 1'b0;
  logic dc_bus_low = 0, uv_trip = 0, sw_ilimit = 0, hw_ilimit = 0, dip_stop = 0, retry_on = 0, fwd_req = 0;
  logic above_start_freq = 0, dc_brake = 0, olp_engaged = 0, alarm_mode = 0, motor_stopped = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, seed = 32'h9a92_aabb;
  logic [15:0] thermal_value = 0, output_current = 16'h0100, out_freq = 0, ref_freq = 0, display_value;
  logic [2:0] life_expired = 0, menu_index;
  logic [1:0] which = 0, term_out;
  logic pready, pslverr, key_up, key_down, key_run, key_stop, forward_run_cmd, run_motor, display_blink;
  logic [32:0] exp_q[$], msk_q[$], seen, e, m; // Notes of expected results
  logic [7:0] sp, rf; // Random speed coefficient and frequency
  int miscompares = 0, n_compared = 0, tk = 0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) tk <= tk + int'(presetn); // Edges since reset release, for the display phase
  drive_status #(.MS_CYCLES_P(MSP)) drive_status_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dc_bus_low, .uv_trip, .sw_ilimit, .hw_ilimit, .dip_stop,
    .thermal_value, .output_current, .retry_on, .life_expired, .above_start_freq, .dc_brake, .olp_engaged,
    .alarm_mode, .motor_stopped, .out_freq, .ref_freq, .key_up, .key_down, .key_run, .key_stop,
    .forward_run_cmd, .term_out, .run_motor, .display_value, .display_blink, .menu_index);
  keypad_model keypad_model_inst (.pclk, .go, .which, .fwd_req(fwd_req), .key_up, .key_down, .key_run,
    .key_stop, .forward_run_cmd);
  // Take the oldest note whenever read data or a look appears
  always @(posedge pclk) begin
    if ((psel && penable && pready && !pwrite) || look) begin
      seen = look ? 33'({display_value, display_blink, run_motor, menu_index, term_out}) : {pslverr, prdata};
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      n_compared++;
      if ((seen & m) !== (e & m)) begin
        $display("ERROR %s expected %h seen %h", look ? "outputs" : "read", e & m, seen & m);
        miscompares++;
      end
    end
  end
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; a read notes {pslverr, prdata}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) begin
      exp_q.push_back(x);
      msk_q.push_back({33{1'b1}});
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Note a masked view of the level outputs and sample it next edge
  task automatic lk(input logic [32:0] x, input logic [32:0] k);
    @(posedge pclk);
    exp_q.push_back(x);
    msk_q.push_back(k);
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask
  task automatic press(input logic [1:0] k);
    @(posedge pclk);
    go <= 1'b1;
    which <= k;
    @(posedge pclk);
    go <= 1'b0;
    cyc(16);
  endtask
  // Raise or drop the condition behind flag i; any i above 9 drives motor stopped
  task automatic stim(input int i, input logic v);
    @(posedge pclk);
    case (i)
      0: dc_bus_low <= v;
      1: sw_ilimit <= v;
      2: thermal_value <= v ? 16'h0200 : 16'h0000;
      3: retry_on <= v;
      4: life_expired <= {v, 2'b00};
      5: dc_brake <= v;
      6: olp_engaged <= v;
      7: output_current <= v ? 16'h0200 : 16'h0100;
      8: output_current <= v ? 16'h0000 : 16'h0100;
      9: alarm_mode <= v;
      default: motor_stopped <= v;
    endcase
  endtask
  // Guard against a hang anywhere
  initial begin
    #1_000_000;
    miscompares++;
    close_out();
  end
  initial begin
    cyc(4);
    presetn <= 1'b1;
    apb(0, CTRL_OFS, 0, 33'h0);
    apb(0, LEVEL_OFS, 0, {17'h0, LEVEL_RST});
    apb(0, DELAY_OFS, 0, {17'h0, DELAY_RST});
    apb(0, OUTSEL_OFS, 0, {17'h0, OUTSEL_RST});
    apb(0, COEF_OFS, 0, {1'b0, COEF_RST});
    apb(0, 8'h40, 0, {1'b1, 32'h0});
    apb(1, DELAY_OFS, 32'h0000_0002, 0);
    // Each flag but power dip on term0: on, then held or gone, then gone
    for (int i = 0; i < 10; i++) begin
      apb(1, OUTSEL_OFS, {16'h0, 8'h63, 1'b0, CODE[i]}, 0);
      stim(i, 1'b1);
      cyc(40);
      lk(33'h1, 33'h1);
      stim(i, 1'b0);
      cyc(200);
      lk({32'h0, i inside {1, 6, 7, 8}}, 33'h1);
      cyc(260);
      lk(33'h0, 33'h1);
    end
    apb(1, OUTSEL_OFS, 32'h0000_6383, 0);
    lk(33'h1, 33'h3);
    sp = 8'($random(seed));
    rf = 8'($random(seed)) | 8'h01; // Nonzero: dip flag holds and feed has a divisor
    ref_freq <= {8'h0, rf};
    apb(1, COEF_OFS, {8'h0, sp, 16'h0001}, 0);
    apb(0, SPEED_OFS, 0, {17'h0, {8'h0, sp} * {8'h0, rf}});
    // Power dip in restart mode 4 stands until output frequency regains the reference
    apb(1, CTRL_OFS, 32'h0000_0040, 0);
    apb(1, OUTSEL_OFS, 32'h0000_6306, 0);
    dip_stop <= 1'b1;
    cyc(4);
    lk(33'h1, 33'h1);
    dip_stop <= 1'b0;
    cyc(4);
    lk(33'h1, 33'h1);
    out_freq <= {8'h0, rf};
    cyc(4);
    lk(33'h0, 33'h1);
    lk({10'h0, {8'h0, sp} * {8'h0, rf}, 7'h0}, 33'h7F_FF80);
    apb(0, FEED_OFS, 0, {9'h0, sp / rf, 8'h0, sp / rf});
    apb(1, TIMER_OFS, 0, 0);
    apb(0, TIMER_OFS, 0, {19'h0, TIMER_MIN});
    apb(1, TIMER_OFS, 32'h0000_FFFF, 0);
    apb(0, TIMER_OFS, 0, {19'h0, TIMER_MAX});
    apb(1, TIMER_OFS, 32'h0000_0001, 0);
    apb(1, CTRL_OFS, 32'h0000_0004, 0);
    press(2'h1);
    lk(33'(MENU_LAST) << 2, 33'h1C);
    press(2'h0);
    lk(33'(MENU_FIRST) << 2, 33'h1C);
    apb(1, CTRL_OFS, 32'h0000_0002, 0);
    cyc(4);
    lk(33'(MENU_CHECK) << 2, 33'h1C);
    apb(1, CTRL_OFS, 32'h0000_0000, 0);
    press(2'h0);
    lk(33'(MENU_FIRST) << 2, 33'h1C);
    apb(1, CTRL_OFS, 32'h0000_0001, 0);
    press(2'h2);
    cyc(20);
    lk(33'h20, 33'h20);
    cyc(4100);
    lk(33'h0, 33'h20);
    stim(10, 1'b1);
    cyc(20);
    lk(33'h40, 33'h60);
    // Stop key ends the blink; timer count item then shows the preset
    press(2'h3);
    apb(1, CTRL_OFS, 32'h0000_0D01, 0);
    lk({10'h0, 16'h0001, 7'h0}, 33'h7F_FFC0);
    // Forward start: count out, then end indication and zero count alternate each half second
    fwd_req <= 1'b1;
    cyc(20);
    lk(33'h20, 33'h20);
    cyc(4100);
    // Move to mid half-period so the phase is unambiguous
    for (int j = 0; j < MSP * BLINK_MS && tk % (MSP * BLINK_MS) != 1000; j++) begin
      @(posedge pclk);
    end
    repeat (2) begin
      lk({10'h0, ((tk / (MSP * BLINK_MS)) % 2) ? END_CODE : 16'h0000, 7'h0}, 33'h7F_FFE0);
      cyc(MSP * BLINK_MS - 2);
    end
    fwd_req <= 1'b0;
    cyc(8);
    lk({10'h0, 16'h0001, 7'h0}, 33'h7F_FFE0);
    close_out();
  end
endmodule
